// *** cdm_map.svh ***
`ifndef CDM_MAP_SVH
`define CDM_MAP_SVH

// apb register offsets (byte addresses)
`define CDM_A_INSTR   12'h000
`define CDM_A_STAT    12'h004
`define CDM_A_RFSEL   12'h008
`define CDM_A_RFDATA  12'h00c
`define CDM_A_SP      12'h010
`define CDM_A_MADDR   12'h014
`define CDM_A_MDATA   12'h018
`define CDM_A_PDATA   12'h01c

// status word fields
`define CDM_SW_BUSY   0
`define CDM_SW_ILL    1
`define CDM_SW_SLEEP  2
`define CDM_SW_FLAGS  8

// instruction word fields
`define CDM_F_OP      26
`define CDM_F_RD      21
`define CDM_F_SRC     16

// reset values and fixed locations
`define CDM_SP_RST    16'h00ff
`define CDM_X_LO      5'h1a
`define CDM_Z_SEL     2'h2
`define CDM_IO_FLAGS  6'h3f
`define CDM_IO_SPH    6'h3e
`define CDM_IO_SPL    6'h3d

// execution lengths in clock cycles
`define CDM_CYC_ONE   2'h1
`define CDM_CYC_MEM   2'h2
`define CDM_CYC_CODE  2'h3

`endif

// *** cdm_pkg.sv ***
package cdm_pkg;

    typedef enum logic [5:0] {
        flag_set_op          = 6'h00,
        flag_clear_op        = 6'h01,
        reg_copy_op          = 6'h02,
        reg_pair_copy_op     = 6'h03,
        immediate_load_op    = 6'h04,
        indirect_load_op     = 6'h05,
        displaced_load_op    = 6'h06,
        direct_load_op       = 6'h07,
        indirect_write_op    = 6'h08,
        displaced_write_op   = 6'h09,
        direct_write_op      = 6'h0a,
        code_memory_read_op  = 6'h0b,
        code_memory_write_op = 6'h0c,
        io_in_op             = 6'h0d,
        io_out_op            = 6'h0e,
        stack_push_op        = 6'h0f,
        stack_pop_op         = 6'h10,
        nop_op               = 6'h11,
        sleep_op             = 6'h12,
        watchdog_restart_op  = 6'h13,
        debug_halt_op        = 6'h14
    } cdm_op_t;

    typedef enum {pm_plain, pm_post, pm_pre, pm_disp} cdm_ptr_mode_t;

    typedef enum {cs_idle, cs_run, cs_cw} cdm_state_t;

endpackage : cdm_pkg

// *** cdm_agu_if.sv ***
`timescale 1ns/1ps
interface cdm_agu_if import cdm_pkg::*;;
    logic [15:0]   ptr;
    cdm_ptr_mode_t mode;
    logic [5:0]    disp;
    logic [15:0]   addr;
    logic [15:0]   ptr_next;
    logic          ptr_wr;
    modport core (output ptr, mode, disp, input addr, ptr_next, ptr_wr);
    modport unit (input ptr, mode, disp, output addr, ptr_next, ptr_wr);
endinterface : cdm_agu_if

// *** cdm_agu.sv ***
`timescale 1ns/1ps
module cdm_agu import cdm_pkg::*; (
    input  wire logic  i_clk_sys,
    input  wire logic  i_rst,
    cdm_agu_if.unit    agu
);

    always_comb begin
        agu.addr     = agu.ptr;
        agu.ptr_next = agu.ptr;
        agu.ptr_wr   = 1'b0;
        unique case (agu.mode)
            pm_plain: ;
            pm_post: begin
                agu.ptr_next = agu.ptr + 16'h0001;
                agu.ptr_wr   = 1'b1;
            end
            pm_pre: begin
                agu.ptr_next = agu.ptr - 16'h0001;
                agu.addr     = agu.ptr - 16'h0001;
                agu.ptr_wr   = 1'b1;
            end
            pm_disp: agu.addr = agu.ptr + {10'h000, agu.disp};
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    chk_predec_addr: assert property (
        agu.mode == pm_pre |-> agu.addr == agu.ptr - 16'h0001 && agu.ptr_next == agu.addr)
        else $error("pre-decrement address is not pointer minus one");
    chk_disp_no_wr: assert property (
        agu.mode == pm_disp |-> !agu.ptr_wr && agu.addr == agu.ptr + {10'h000, agu.disp})
        else $error("displaced access moved the pointer or used wrong address");
    chk_postinc_addr: assert property (
        agu.mode == pm_post |-> agu.addr == agu.ptr && agu.ptr_next == agu.ptr + 16'h0001)
        else $error("post-increment used wrong address or step");

endmodule : cdm_agu

// *** cdm_core.sv ***
`timescale 1ns/1ps
`include "cdm_map.svh"
module cdm_core import cdm_pkg::*; #(
    parameter bit BIG_MEM = 1'b1
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_cw_done,
    input  wire logic        i_debug_en,
    output logic             o_sleep_req,
    output logic             o_wdt_restart,
    output logic             o_debug_halt,
    output logic             o_cw_req,
    output logic             o_sleeping
);

    logic [7:0]  rf_q   [0:31];
    logic [7:0]  dmem_q [0:255];
    logic [7:0]  pmem_q [0:255];
    logic [7:0]  io_q   [0:7];
    logic [7:0]  flags_q;
    logic [15:0] sp_q;
    logic [31:0] instr_q;
    logic [1:0]  cnt_q;
    logic [4:0]  rfsel_q;
    logic [7:0]  maddr_q;
    logic        illegal_q;
    logic        sleeping_q;
    logic [1:0]  cw_sync_q;
    logic [1:0]  dbg_sync_q;
    logic [31:0] prdata_q;
    logic        sleep_q;
    logic        wdt_q;
    logic        dbg_q;
    cdm_state_t  state_q;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [1:0] op_cycles(input logic [5:0] code);
        case (cdm_op_t'(code))
            indirect_load_op, displaced_load_op, direct_load_op,
            indirect_write_op, displaced_write_op, direct_write_op,
            stack_push_op, stack_pop_op: op_cycles = `CDM_CYC_MEM;
            code_memory_read_op:         op_cycles = `CDM_CYC_CODE;
            default:                     op_cycles = `CDM_CYC_ONE;
        endcase
    endfunction : op_cycles

    function automatic logic op_legal(input logic [31:0] w, input logic big);
        logic [1:0] sel;
        sel = w[`CDM_F_SRC+1:`CDM_F_SRC];
        case (cdm_op_t'(w[31:`CDM_F_OP]))
            indirect_load_op, indirect_write_op: op_legal = sel != 2'h3 && w[1:0] != 2'h3;
            displaced_load_op, displaced_write_op: op_legal = sel == 2'h1 || sel == 2'h2;
            code_memory_read_op: op_legal = big || w[1:0] == 2'h0;
            flag_set_op, flag_clear_op, reg_copy_op, reg_pair_copy_op,
            immediate_load_op, direct_load_op, direct_write_op,
            code_memory_write_op, io_in_op, io_out_op, stack_push_op,
            stack_pop_op, nop_op, sleep_op, watchdog_restart_op,
            debug_halt_op: op_legal = 1'b1;
            default: op_legal = 1'b0;
        endcase
    endfunction : op_legal

    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = a == `CDM_A_INSTR || a == `CDM_A_STAT || a == `CDM_A_RFSEL ||
                   a == `CDM_A_RFDATA || a == `CDM_A_SP || a == `CDM_A_MADDR ||
                   a == `CDM_A_MDATA || a == `CDM_A_PDATA;
    endfunction : addr_hit

    ////////////////////////////////////////////////////////////////////////////
    // instruction fields
    cdm_op_t     op;
    logic [4:0]  rd;
    logic [4:0]  src;
    logic [15:0] imm;
    logic        busy;
    logic        last;
    assign op   = cdm_op_t'(instr_q[31:`CDM_F_OP]);
    assign rd   = instr_q[`CDM_F_RD+4:`CDM_F_RD];
    assign src  = instr_q[`CDM_F_SRC+4:`CDM_F_SRC];
    assign imm  = instr_q[15:0];
    assign busy = state_q != cs_idle;
    assign last = state_q == cs_run && cnt_q == 2'h0;

    // apb slave: zero wait states, writes only while idle (status always)
    logic acc;
    logic wr_ok;
    logic start;
    logic req_ok;
    assign acc    = i_psel & i_penable;
    assign req_ok = addr_hit(i_paddr) && (!i_pwrite || ((!busy || i_paddr == `CDM_A_STAT)
                    && (i_paddr != `CDM_A_INSTR || op_legal(i_pwdata, BIG_MEM))));
    assign wr_ok     = acc && i_pwrite && req_ok;
    assign start     = wr_ok && i_paddr == `CDM_A_INSTR;
    assign o_pready  = 1'b1;
    assign o_pslverr = acc && !req_ok;
    assign o_prdata  = prdata_q;

    // pointer selection and address generation
    cdm_agu_if agu ();
    logic [1:0]  ptr_sel;
    logic [4:0]  ptr_lo;
    logic [15:0] ptr_val;
    logic [15:0] ea;
    logic        ptr_upd;
    logic [7:0]  src_byte;
    logic [7:0]  load_byte;
    logic [7:0]  io_byte;
    logic [7:0]  fmask;
    logic [5:0]  port;
    assign ptr_sel = (op == code_memory_read_op || op == code_memory_write_op)
                     ? `CDM_Z_SEL : src[1:0];
    assign ptr_lo   = `CDM_X_LO + {2'h0, ptr_sel, 1'b0};
    assign ptr_val  = {rf_q[ptr_lo | 5'h01], rf_q[ptr_lo]};
    assign agu.ptr  = ptr_val;
    assign agu.disp = imm[5:0];
    assign ea       = (op == direct_load_op || op == direct_write_op) ? imm : agu.addr;
    assign ptr_upd  = last && agu.ptr_wr;
    assign src_byte = rf_q[rd];
    assign load_byte = dmem_q[ea[7:0]];
    assign fmask    = 8'h01 << imm[2:0];
    assign port     = imm[5:0];

    always_comb begin
        agu.mode = pm_plain;
        case (op)
            indirect_load_op, indirect_write_op:
                agu.mode = imm[1:0] == 2'h1 ? pm_post : imm[1:0] == 2'h2 ? pm_pre : pm_plain;
            displaced_load_op, displaced_write_op: agu.mode = pm_disp;
            code_memory_read_op: agu.mode = imm[1] ? pm_post : pm_plain;
            default: agu.mode = pm_plain;
        endcase
    end

    always_comb begin
        if (port == `CDM_IO_FLAGS) io_byte = flags_q;
        else if (port == `CDM_IO_SPH) io_byte = sp_q[15:8];
        else if (port == `CDM_IO_SPL) io_byte = sp_q[7:0];
        else io_byte = io_q[port[2:0]];
    end

    cdm_agu u_agu (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .agu       (agu.unit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_q <= cs_idle;
            cnt_q   <= 2'h0;
            instr_q <= 32'h0000_0000;
        end else begin
            unique case (state_q)
                cs_idle: if (start) begin
                    instr_q <= i_pwdata;
                    cnt_q   <= op_cycles(i_pwdata[31:`CDM_F_OP]) - 2'h1;
                    state_q <= cs_run;
                end
                cs_run: if (cnt_q == 2'h0) begin
                    state_q <= op == code_memory_write_op ? cs_cw : cs_idle;
                end else begin
                    cnt_q <= cnt_q - 2'h1;
                end
                cs_cw: if (cw_sync_q[1]) state_q <= cs_idle;
            endcase
        end
    end

    // pin synchronisers
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            cw_sync_q  <= 2'h0;
            dbg_sync_q <= 2'h0;
        end else begin
            cw_sync_q  <= {cw_sync_q[0], i_cw_done};
            dbg_sync_q <= {dbg_sync_q[0], i_debug_en};
        end
    end

    // working registers
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            for (int i = 0; i < 32; i++) rf_q[i] <= 8'h00;
        end else if (last) begin
            if (ptr_upd) begin
                rf_q[ptr_lo]         <= agu.ptr_next[7:0];
                rf_q[ptr_lo | 5'h01] <= agu.ptr_next[15:8];
            end
            case (op)
                reg_copy_op: rf_q[rd] <= rf_q[src];
                reg_pair_copy_op: begin
                    rf_q[{rd[4:1], 1'b0}] <= rf_q[{src[4:1], 1'b0}];
                    rf_q[{rd[4:1], 1'b1}] <= rf_q[{src[4:1], 1'b1}];
                end
                immediate_load_op: rf_q[rd] <= imm[7:0];
                indirect_load_op, displaced_load_op, direct_load_op:
                    rf_q[rd] <= load_byte;
                stack_pop_op: rf_q[rd] <= dmem_q[sp_q[7:0] + 8'h01];
                code_memory_read_op: rf_q[imm[0] ? rd : 5'h00] <= pmem_q[agu.addr[7:0]];
                io_in_op: rf_q[rd] <= io_byte;
                default: ;
            endcase
        end else if (wr_ok && i_paddr == `CDM_A_RFDATA) begin
            rf_q[rfsel_q] <= i_pwdata[7:0];
        end
    end

    // data space and code space
    always_ff @(posedge i_clk_sys) begin
        if (last && (op == indirect_write_op || op == displaced_write_op
                     || op == direct_write_op)) begin
            dmem_q[ea[7:0]] <= src_byte;
        end else if (last && op == stack_push_op) begin
            dmem_q[sp_q[7:0]] <= src_byte;
        end else if (wr_ok && i_paddr == `CDM_A_MDATA) begin
            dmem_q[maddr_q] <= i_pwdata[7:0];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (state_q == cs_cw && cw_sync_q[1]) begin
            pmem_q[{ptr_val[7:1], 1'b0}] <= rf_q[0];
            pmem_q[{ptr_val[7:1], 1'b1}] <= rf_q[1];
        end else if (wr_ok && i_paddr == `CDM_A_PDATA) begin
            pmem_q[maddr_q] <= i_pwdata[7:0];
        end
    end

    // status register, stack pointer, port space
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            flags_q <= 8'h00;
        end else if (last && op == flag_set_op) begin
            flags_q <= flags_q | fmask;
        end else if (last && op == flag_clear_op) begin
            flags_q <= flags_q & ~fmask;
        end else if (last && op == io_out_op && port == `CDM_IO_FLAGS) begin
            flags_q <= src_byte;
        end else if (wr_ok && i_paddr == `CDM_A_STAT) begin
            flags_q <= i_pwdata[`CDM_SW_FLAGS+7:`CDM_SW_FLAGS];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sp_q <= `CDM_SP_RST;
        end else if (last && op == stack_push_op) begin
            sp_q <= sp_q - 16'h0001;
        end else if (last && op == stack_pop_op) begin
            sp_q <= sp_q + 16'h0001;
        end else if (last && op == io_out_op && port == `CDM_IO_SPH) begin
            sp_q[15:8] <= src_byte;
        end else if (last && op == io_out_op && port == `CDM_IO_SPL) begin
            sp_q[7:0] <= src_byte;
        end else if (wr_ok && i_paddr == `CDM_A_SP) begin
            sp_q <= i_pwdata[15:0];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            for (int i = 0; i < 8; i++) io_q[i] <= 8'h00;
        end else if (last && op == io_out_op && port[5:3] == 3'h0) begin
            io_q[port[2:0]] <= src_byte;
        end
    end

    // control pulses and sleep status level
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sleep_q    <= 1'b0;
            wdt_q      <= 1'b0;
            dbg_q      <= 1'b0;
            sleeping_q <= 1'b0;
        end else begin
            sleep_q <= last && op == sleep_op;
            wdt_q   <= last && op == watchdog_restart_op;
            dbg_q   <= last && op == debug_halt_op && dbg_sync_q[1];
            if (last && op == sleep_op) sleeping_q <= 1'b1;
            else if (start) sleeping_q <= 1'b0;
        end
    end
    assign o_sleep_req   = sleep_q;
    assign o_wdt_restart = wdt_q;
    assign o_debug_halt  = dbg_q;
    assign o_sleeping    = sleeping_q;
    assign o_cw_req      = state_q == cs_cw;

    // apb side registers and read data
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            rfsel_q   <= 5'h00;
            maddr_q   <= 8'h00;
            illegal_q <= 1'b0;
        end else begin
            if (wr_ok && i_paddr == `CDM_A_RFSEL) rfsel_q <= i_pwdata[4:0];
            if (wr_ok && i_paddr == `CDM_A_MADDR) maddr_q <= i_pwdata[7:0];
            if (acc && i_pwrite && i_paddr == `CDM_A_INSTR && !req_ok) illegal_q <= 1'b1;
            else if (wr_ok && i_paddr == `CDM_A_STAT && i_pwdata[`CDM_SW_ILL])
                illegal_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (i_psel && !i_penable) begin
            case (i_paddr)
                `CDM_A_INSTR:  prdata_q <= instr_q;
                `CDM_A_STAT:   prdata_q <= {16'h0000, flags_q, 5'h00, sleeping_q, illegal_q, busy};
                `CDM_A_RFSEL:  prdata_q <= {27'h000_0000, rfsel_q};
                `CDM_A_RFDATA: prdata_q <= {24'h00_0000, rf_q[rfsel_q]};
                `CDM_A_SP:     prdata_q <= {16'h0000, sp_q};
                `CDM_A_MADDR:  prdata_q <= {24'h00_0000, maddr_q};
                `CDM_A_MDATA:  prdata_q <= {24'h00_0000, dmem_q[maddr_q]};
                `CDM_A_PDATA:  prdata_q <= {24'h00_0000, pmem_q[maddr_q]};
                default:       prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    logic ptr_clash;
    assign ptr_clash = rd[4:1] == ptr_lo[4:1];

    chk_flag_one_cycle: assert property (
        start && i_pwdata[31:27] == 5'h00 |=> last ##1 !busy)
        else $error("flag instruction did not finish in one cycle");
    chk_flag_only_bit: assert property (
        last && op == flag_set_op |=> flags_q == ($past(flags_q) | $past(fmask)))
        else $error("flag set changed other flags");
    chk_flag_clear_bit: assert property (
        last && op == flag_clear_op |=> flags_q == ($past(flags_q) & ~$past(fmask)))
        else $error("flag clear changed other flags");
    chk_mem_two_cycles: assert property (
        start && op_cycles(i_pwdata[31:`CDM_F_OP]) == `CDM_CYC_MEM
        |=> busy [*2] ##1 !busy)
        else $error("memory instruction did not take two cycles");
    chk_postinc_ptr: assert property (
        last && agu.mode == pm_post && !ptr_clash |=> ptr_val == $past(ptr_val) + 16'h0001)
        else $error("post-increment pointer not advanced");
    chk_predec_ptr: assert property (
        last && agu.mode == pm_pre && !ptr_clash |=> ptr_val == $past(ptr_val) - 16'h0001)
        else $error("pre-decrement pointer not lowered");
    chk_disp_keeps_ptr: assert property (
        last && agu.mode == pm_disp && !ptr_clash |=> $stable(ptr_val))
        else $error("displaced access changed the pointer");
    chk_load_data: assert property (
        last && op == direct_load_op |=> rf_q[$past(rd)] == $past(load_byte))
        else $error("direct load returned wrong byte");
    chk_store_data: assert property (
        last && op == direct_write_op |=> dmem_q[$past(imm[7:0])] == $past(src_byte))
        else $error("direct store wrote wrong byte");
    chk_code_three: assert property (
        start && i_pwdata[31:`CDM_F_OP] == 6'h0b |=> busy [*3] ##1 !busy)
        else $error("code read did not take three cycles");
    chk_push_sp: assert property (
        last && op == stack_push_op |=> sp_q == $past(sp_q) - 16'h0001 && $stable(flags_q))
        else $error("push did not lower the stack pointer");
    chk_pop_sp: assert property (
        last && op == stack_pop_op |=> sp_q == $past(sp_q) + 16'h0001 && $stable(flags_q))
        else $error("pop did not raise the stack pointer");
    chk_sleep_pulse: assert property (
        last && op == sleep_op |=> o_sleep_req && o_sleeping ##1 !o_sleep_req)
        else $error("sleep request not a single pulse");
    chk_wdt_pulse: assert property (
        last && op == watchdog_restart_op |=> o_wdt_restart && $stable(flags_q) ##1 !o_wdt_restart)
        else $error("watchdog restart not a single pulse");
    chk_break_gated: assert property (
        o_debug_halt |-> $past(last && op == debug_halt_op && dbg_sync_q[1]))
        else $error("debug halt without enabled debug");
    chk_small_variant: assert property (
        !BIG_MEM && acc && i_pwrite && i_paddr == `CDM_A_INSTR
        && i_pwdata[31:`CDM_F_OP] == 6'h0b && i_pwdata[1:0] != 2'h0 |-> !start && o_pslverr)
        else $error("large-variant form accepted on small variant");
    chk_move_flags: assert property (
        last && (op == reg_copy_op || op == immediate_load_op || op == io_in_op)
        |-> $past(start) ##1 $stable(flags_q))
        else $error("copy was not single cycle or changed flags");
    chk_cw_wait: assert property (
        state_q == cs_cw && cw_sync_q[1] |=> !busy && pmem_q[{$past(ptr_val[7:1]), 1'b0}]
        == $past(rf_q[0]))
        else $error("code write did not store the pair");

    cov_post_load: cover property (last && op == indirect_load_op && agu.mode == pm_post);
    cov_push_pop: cover property (last && op == stack_push_op ##[1:20] last && op == stack_pop_op);
    cov_cw_done: cover property (state_q == cs_cw ##1 !busy);
    cov_refused: cover property (o_pslverr);

endmodule : cdm_core

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import cdm_pkg::*;
    logic        i_clk_sys = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic [11:0] i_paddr = 0;
    logic [31:0] i_pwdata = 0, o_prdata;
    logic        o_pready, o_pslverr, i_debug_en = 0, o_sleep_req, o_wdt_restart;
    logic        o_debug_halt, o_cw_req, o_sleeping, i_cw_done = 0;
    int          fails = 0, num_checks = 0, cyc = 0, n_slp = 0, n_wdt = 0, n_dbg = 0;
    logic [31:0] r, fl;
    logic        e;

    cdm_core DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_cw_done(i_cw_done), .i_debug_en(i_debug_en), .o_sleep_req(o_sleep_req),
        .o_wdt_restart(o_wdt_restart), .o_debug_halt(o_debug_halt), .o_cw_req(o_cw_req),
        .o_sleeping(o_sleeping));

    always #5 i_clk_sys = ~i_clk_sys;

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge i_clk_sys) begin
        cyc++;
        if (o_sleep_req === 1'b1) n_slp++;
        if (o_wdt_restart === 1'b1) n_wdt++;
        if (o_debug_halt === 1'b1) n_dbg++;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_psel <= 1; i_penable <= 0; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
        @(posedge i_clk_sys);
        i_penable <= 1;
        do @(posedge i_clk_sys); while (o_pready !== 1'b1);
        r = o_prdata; e = o_pslverr;
        i_psel <= 0; i_penable <= 0;
    endtask : apb

    function automatic logic [31:0] ins(input logic [5:0] op, input logic [4:0] rd,
                                        input logic [4:0] src, input logic [15:0] imm);
        return {op, rd, src, imm};
    endfunction : ins

    // start an instruction and poll status until it retires
    task automatic run(input logic [31:0] w);
        apb(1, 12'h000, w);
        r = 32'h0000_0001;
        while (r[0] !== 1'b0) apb(0, 12'h004, 32'h0000_0000);
    endtask : run

    task automatic reg_is(input string n, input logic [4:0] idx, input logic [7:0] v);
        apb(1, 12'h008, {27'h0, idx});
        apb(0, 12'h00c, 32'h0000_0000);
        chk(n, {24'h0, v}, r);
    endtask : reg_is

    task automatic mem_is(input string n, input logic [7:0] a, input logic [7:0] v);
        apb(1, 12'h014, {24'h0, a});
        apb(0, 12'h018, 32'h0000_0000);
        chk(n, {24'h0, v}, r);
    endtask : mem_is

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge i_clk_sys);
        i_rst <= 0;
        apb(0, 12'h004, 32'h0000_0000);
        chk("stat_rst", 32'h0000_0000, r);
        apb(0, 12'h010, 32'h0000_0000);
        chk("sp_rst", 32'h0000_00ff, r);
        fl = 0;
        for (int i = 0; i < 16; i++) begin
            run(ins((i < 8) ? 6'h00 : 6'h01, 5'h0, 5'h0, 16'(i % 8)));
            fl[8 + i % 8] = (i < 8);
            apb(0, 12'h004, 32'h0000_0000);
            chk("flag_op", fl, r);
        end
        run(ins(6'h04, 5'd26, 5'h0, 16'h0010));
        run(ins(6'h04, 5'd27, 5'h0, 16'h0000));
        run(ins(6'h04, 5'd5, 5'h0, 16'h005a));
        run(ins(6'h02, 5'd7, 5'd5, 16'h0000));
        reg_is("copy", 5'd7, 8'h5a);
        run(ins(6'h08, 5'd5, 5'h0, 16'h0001));
        mem_is("wr_post_mem", 8'h10, 8'h5a);
        reg_is("wr_post_ptr", 5'd26, 8'h11);
        run(ins(6'h05, 5'd8, 5'h0, 16'h0002));
        reg_is("rd_pre_dat", 5'd8, 8'h5a);
        reg_is("rd_pre_ptr", 5'd26, 8'h10);
        run(ins(6'h05, 5'd9, 5'h0, 16'h0001));
        reg_is("rd_post_dat", 5'd9, 8'h5a);
        reg_is("rd_post_ptr", 5'd26, 8'h11);
        run(ins(6'h0a, 5'd7, 5'h0, 16'h0020));
        mem_is("wr_dir", 8'h20, 8'h5a);
        run(ins(6'h07, 5'd10, 5'h0, 16'h0020));
        reg_is("rd_dir", 5'd10, 8'h5a);
        run(ins(6'h04, 5'd28, 5'h0, 16'h0030));
        run(ins(6'h04, 5'd29, 5'h0, 16'h0000));
        run(ins(6'h09, 5'd5, 5'h1, 16'h0003));
        mem_is("wr_disp", 8'h33, 8'h5a);
        run(ins(6'h06, 5'd11, 5'h1, 16'h0003));
        reg_is("rd_disp", 5'd11, 8'h5a);
        reg_is("disp_ptr", 5'd28, 8'h30);
        run(ins(6'h0f, 5'd5, 5'h0, 16'h0000));
        apb(0, 12'h010, 32'h0000_0000);
        chk("push_sp", 32'h0000_00fe, r);
        mem_is("push_mem", 8'hff, 8'h5a);
        run(ins(6'h10, 5'd12, 5'h0, 16'h0000));
        reg_is("pop_dat", 5'd12, 8'h5a);
        apb(0, 12'h010, 32'h0000_0000);
        chk("pop_sp", 32'h0000_00ff, r);
        run(ins(6'h13, 5'h0, 5'h0, 16'h0000));
        chk("wdt_pulse", 32'd1, n_wdt);
        run(ins(6'h12, 5'h0, 5'h0, 16'h0000));
        apb(0, 12'h004, 32'h0000_0000);
        chk("sleep_stat", 32'h0000_0004, r);
        chk("sleep_pulse", 32'd1, n_slp);
        run(ins(6'h14, 5'h0, 5'h0, 16'h0000));
        chk("halt_off", 32'd0, n_dbg);
        i_debug_en <= 1;
        repeat (4) @(posedge i_clk_sys);
        run(ins(6'h14, 5'h0, 5'h0, 16'h0000));
        chk("halt_on", 32'd1, n_dbg);
        run(ins(6'h04, 5'd0, 5'h0, 16'h0011));
        run(ins(6'h04, 5'd1, 5'h0, 16'h0022));
        run(ins(6'h04, 5'd30, 5'h0, 16'h0040));
        run(ins(6'h04, 5'd31, 5'h0, 16'h0000));
        apb(1, 12'h000, ins(6'h0c, 5'h0, 5'h0, 16'h0000));
        repeat (2) @(posedge i_clk_sys);
        chk("cw_wait", 32'd1, {31'h0, o_cw_req});
        i_cw_done <= 1;
        r = 32'h0000_0001;
        while (r[0] !== 1'b0) apb(0, 12'h004, 32'h0000_0000);
        chk("cw_done", 32'd0, {31'h0, o_cw_req});
        i_cw_done <= 0;
        run(ins(6'h0b, 5'd13, 5'h0, 16'h0003));
        reg_is("cr_dat", 5'd13, 8'h11);
        reg_is("cr_ptr", 5'd30, 8'h41);
        run(ins(6'h03, 5'd14, 5'd0, 16'h0000));
        reg_is("pair_copy", 5'd15, 8'h22);
        run(ins(6'h0e, 5'd15, 5'h0, 16'h0003));
        run(ins(6'h0d, 5'd16, 5'h0, 16'h0003));
        reg_is("port_io", 5'd16, 8'h22);
        run(ins(6'h08, 5'd13, 5'h0, 16'h0002));
        mem_is("wr_pre_mem", 8'h10, 8'h11);
        reg_is("wr_pre_ptr", 5'd26, 8'h10);
        run(ins(6'h0b, 5'h0, 5'h0, 16'h0000));
        reg_is("cr_dflt", 5'h0, 8'h22);
        apb(0, 12'h004, 32'h0000_0000);
        chk("flags_kept", 32'h0000_0000, r);
        apb(0, 12'h020, 32'h0000_0000);
        chk("unmapped", 32'd1, {31'h0, e});
        apb(1, 12'h000, 32'hfc00_0000);
        chk("illegal_err", 32'd1, {31'h0, e});
        tally_and_finish();
    end
endmodule : testbench
